// file: rtl/gpio_out_defines.svh
`ifndef GPIO_OUT_DEFINES_SVH
`define GPIO_OUT_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_PIN0_SEL     8'h53
`define ADDR_PIN2_SEL     8'h55
`define ADDR_LEVELS       8'h56
`define ADDR_POLARITY     8'h57
`define ADDR_DIE_ID       8'h58

// ----------------------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------------------
`define REG_RESET         8'h00
`define SEL_MSB           4
`define PIN_BIT_BASE      3
`define NUM_PINS          3
`define PIN_FIRST         0
`define PIN_MUTE          1
`define PIN_SECOND        2
`define PIN_FIRST_BIT     3
`define PIN_MUTE_BIT      4
`define PIN_SECOND_BIT    5
`define DIV4_RESET        2'h0
`define DIV4_STEP         2'h1

// ----------------------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------------------
`define SEL_OFF           5'h00
`define SEL_DSP           5'h01
`define SEL_SOFT          5'h02
`define SEL_AMUTE_BOTH    5'h03
`define SEL_AMUTE_L       5'h04
`define SEL_AMUTE_R       5'h05
`define SEL_CLK_INVALID   5'h06
`define SEL_SERIAL_OUT    5'h07
`define SEL_ANA_MUTE_L    5'h08
`define SEL_ANA_MUTE_R    5'h09
`define SEL_PLL_LOCK      5'h0a
`define SEL_CP_CLK        5'h0b
`define SEL_PLL_DIV4      5'h10
`define SEL_OSC_DIV4      5'h11
`define SEL_IMP_L         5'h12
`define SEL_IMP_R         5'h13
`define SEL_OFFSET_CAL    5'h15
`define SEL_CLK_ERR       5'h16
`define SEL_CLK_CHG       5'h17
`define SEL_CLK_MISS      5'h18
`define SEL_CLK_HALT      5'h19
`define SEL_DSP_BOOT      5'h1a
`define SEL_CP_VALID_N    5'h1b

`endif

// file: rtl/gpio_out_pkg.sv
package gpio_out_pkg;

    typedef logic [4:0] source_code_type;

    typedef struct packed {
        logic auto_mute_left;
        logic auto_mute_right;
        logic serial_audio_out;
        logic analog_mute_left_n;
        logic analog_mute_right_n;
        logic pll_lock;
        logic charge_pump_clk;
        logic imp_sense_left;
        logic imp_sense_right;
        logic offset_calibrating;
        logic clk_error;
        logic clk_changing;
        logic clk_missing;
        logic clk_halt;
        logic dsp_boot_done;
        logic charge_pump_valid_n;
    } source_flags_type;

    typedef struct packed {
        logic level;
        logic oe;
    } pin_drive_type;

    typedef struct packed {
        logic       prev;
        logic [1:0] count;
    } div4_state_type;

    typedef struct packed {
        logic [7:0] pin0_sel_reg;
        logic [7:0] pin2_sel_reg;
        logic [7:0] levels_reg;
        logic [7:0] polarity_reg;
        logic [7:0] rdata;
        logic       rvalid;
        logic [2:0] pin_level;
        logic [2:0] pin_oe;
    } ctrl_state_type;

endpackage

// file: rtl/clock_div4.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_out_defines.svh"

module clock_div4
    import gpio_out_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic src_clk,
    output var  logic div_clk
);

    div4_state_type s_q;
    div4_state_type s_d;

    // ------------------------------------------------------------------------
    // count rising edges of the sampled source
    // ------------------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.prev = src_clk;
        if (src_clk && !s_q.prev) begin
            s_d.count = s_q.count + `DIV4_STEP;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '{prev: 1'b0, count: `DIV4_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign div_clk = s_q.count[1];

endmodule
`default_nettype wire

// file: rtl/pin_source_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_out_defines.svh"

module pin_source_mux
    import gpio_out_pkg::*;
(
    input  wire logic             select,
    input  wire source_code_type  code,
    input  wire logic             dsp_level,
    input  wire logic             soft_level,
    input  wire source_flags_type flags,
    input  wire logic             pll_div4,
    input  wire logic             osc_div4,
    output var  logic             selected
);

    // ------------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------------
    always_comb begin
        case (code)
            `SEL_OFF:         selected = 1'b0;                                   // RQ2
            `SEL_DSP:         selected = dsp_level;                              // RQ3
            `SEL_SOFT:        selected = soft_level;                             // RQ4
            `SEL_AMUTE_BOTH:  selected = flags.auto_mute_left & flags.auto_mute_right; // RQ5
            `SEL_AMUTE_L:     selected = flags.auto_mute_left;                   // RQ5
            `SEL_AMUTE_R:     selected = flags.auto_mute_right;                  // RQ5
            `SEL_CLK_INVALID: selected = flags.clk_error | flags.clk_changing
                                         | flags.clk_missing;                    // RQ22
            `SEL_SERIAL_OUT:  selected = flags.serial_audio_out;                 // RQ6
            `SEL_ANA_MUTE_L:  selected = flags.analog_mute_left_n;               // RQ7
            `SEL_ANA_MUTE_R:  selected = flags.analog_mute_right_n;              // RQ7
            `SEL_PLL_LOCK:    selected = flags.pll_lock;                         // RQ8
            `SEL_CP_CLK:      selected = flags.charge_pump_clk;                  // RQ8
            `SEL_PLL_DIV4:    selected = pll_div4;                               // RQ9
            `SEL_OSC_DIV4:    selected = osc_div4;                               // RQ9
            `SEL_IMP_L:       selected = flags.imp_sense_left;                   // RQ10
            `SEL_IMP_R:       selected = flags.imp_sense_right;                  // RQ10
            `SEL_OFFSET_CAL:  selected = flags.offset_calibrating;               // RQ11
            `SEL_CLK_ERR:     selected = flags.clk_error;                        // RQ12
            `SEL_CLK_CHG:     selected = flags.clk_changing;                     // RQ12
            `SEL_CLK_MISS:    selected = flags.clk_missing;
            `SEL_CLK_HALT:    selected = flags.clk_halt;                         // RQ12
            `SEL_DSP_BOOT:    selected = flags.dsp_boot_done;                    // RQ13
            `SEL_CP_VALID_N:  selected = flags.charge_pump_valid_n;              // RQ13
            default:          selected = 1'b0;                                   // RQ14
        endcase
        if (!select) begin
            selected = 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: rtl/gpio_output_select_control.sv
// Overview of operation
// RQ1: second pin driven only when direction is output
// RQ2: code 0000 holds the pin low
// RQ3: code 0001 routes the dsp level
// RQ4: code 0010 routes level bit 5
// RQ5: codes 0011-0101 route auto-mute flags
// RQ6: code 0111 routes serial audio out
// RQ7: codes 1000/1001 route active-low analog mutes
// RQ8: codes 1010/1011 route pll lock, pump clock
// RQ9: codes 10000/10001 route divided-by-four clocks
// RQ10: codes 10010/10011 route impedance sense flags
// RQ11: code 10101 routes offset calibration flag
// RQ12: clock error, changing, halt on their codes
// RQ13: boot done and pump valid-low flags
// RQ14: unassigned codes give constant zero
// RQ15: level bit 5 sets second pin level
// RQ16: level bit 4 sets mute pin level
// RQ17: level bit 3 sets first pin level
// RQ18: polarity bit 5 inverts second pin
// RQ19: polarity bit 4 inverts mute pin
// RQ20: polarity bit 3 inverts first pin
// RQ21: first pin has its own select field
// RQ22: code 0110 routes combined clock-invalid flag
// RQ23: inversion applied before direction gating
`timescale 1ns/1ns
`default_nettype none
`include "gpio_out_defines.svh"

module gpio_output_select_control
    import gpio_out_pkg::*;
#(
    parameter logic [7:0] DIE_ID = 8'h5a   // arbitrary value
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output var  logic [7:0]       reg_rdata,
    output var  logic             reg_rvalid,
    input  wire logic [2:0]       pin_direction,
    input  wire source_code_type  mute_source_select,
    input  wire logic [2:0]       dsp_pin_level,
    input  wire source_flags_type flags,
    input  wire logic             pll_clk,
    input  wire logic             osc_clk,
    output var  pin_drive_type    first_general_pin,
    output var  pin_drive_type    mute_pin,
    output var  pin_drive_type    second_general_pin
);

    ctrl_state_type  s_q;
    ctrl_state_type  s_d;
    logic            pll_div4;
    logic            osc_div4;
    source_code_type sel_code [`NUM_PINS];
    logic [2:0]      mux_out;
    logic [2:0]      soft_level;
    logic [2:0]      invert;

    // ------------------------------------------------------------------------
    // divided clocks
    // ------------------------------------------------------------------------
    clock_div4 u_pll_div4 (
        .sys_clk (sys_clk),
        .reset   (reset),
        .src_clk (pll_clk),
        .div_clk (pll_div4)
    );

    clock_div4 u_osc_div4 (
        .sys_clk (sys_clk),
        .reset   (reset),
        .src_clk (osc_clk),
        .div_clk (osc_div4)
    );

    // ------------------------------------------------------------------------
    // per-pin source multiplexers
    // ------------------------------------------------------------------------
    assign sel_code[`PIN_FIRST]  = s_q.pin0_sel_reg[`SEL_MSB:0];   // RQ21
    assign sel_code[`PIN_MUTE]   = mute_source_select;
    assign sel_code[`PIN_SECOND] = s_q.pin2_sel_reg[`SEL_MSB:0];

    genvar g;
    generate
        for (g = 0; g < `NUM_PINS; g++) begin : g_pin
            assign soft_level[g] = s_q.levels_reg[`PIN_BIT_BASE + g];   // RQ15 RQ16 RQ17
            assign invert[g]     = s_q.polarity_reg[`PIN_BIT_BASE + g]; // RQ18 RQ19 RQ20
            pin_source_mux u_mux (
                .select     (1'b1),
                .code       (sel_code[g]),
                .dsp_level  (dsp_pin_level[g]),
                .soft_level (soft_level[g]),
                .flags      (flags),
                .pll_div4   (pll_div4),
                .osc_div4   (osc_div4),
                .selected   (mux_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // register bank, read port and pin drive
    // ------------------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = reg_read;
        if (reg_write) begin
            case (reg_addr)
                `ADDR_PIN0_SEL: begin
                    s_d.pin0_sel_reg = reg_wdata;
                end
                `ADDR_PIN2_SEL: begin
                    s_d.pin2_sel_reg = reg_wdata;
                end
                `ADDR_LEVELS: begin
                    s_d.levels_reg = reg_wdata;
                end
                `ADDR_POLARITY: begin
                    s_d.polarity_reg = reg_wdata;
                end
                default: begin
                    s_d.rvalid = reg_read;
                end
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                `ADDR_PIN0_SEL: begin
                    s_d.rdata = s_q.pin0_sel_reg;
                end
                `ADDR_PIN2_SEL: begin
                    s_d.rdata = s_q.pin2_sel_reg;
                end
                `ADDR_LEVELS: begin
                    s_d.rdata = s_q.levels_reg;
                end
                `ADDR_POLARITY: begin
                    s_d.rdata = s_q.polarity_reg;
                end
                `ADDR_DIE_ID: begin
                    s_d.rdata = DIE_ID;
                end
                default: begin
                    s_d.rdata = `REG_RESET;
                end
            endcase
        end
        // invert first, then gate by direction
        s_d.pin_level = (mux_out ^ invert) & pin_direction;   // RQ1 RQ23
        s_d.pin_oe    = pin_direction;                        // RQ1
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '{pin0_sel_reg: `REG_RESET,
                     pin2_sel_reg: `REG_RESET,
                     levels_reg:   `REG_RESET,
                     polarity_reg: `REG_RESET,
                     rdata:        `REG_RESET,
                     rvalid:       1'b0,
                     pin_level:    3'h0,
                     pin_oe:       3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign reg_rdata  = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;

    assign first_general_pin  = '{level: s_q.pin_level[`PIN_FIRST],
                                  oe:    s_q.pin_oe[`PIN_FIRST]};
    assign mute_pin           = '{level: s_q.pin_level[`PIN_MUTE],
                                  oe:    s_q.pin_oe[`PIN_MUTE]};
    assign second_general_pin = '{level: s_q.pin_level[`PIN_SECOND],
                                  oe:    s_q.pin_oe[`PIN_SECOND]};

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_write_levels;
        reg_write && reg_addr == `ADDR_LEVELS;
    endsequence

    sequence s_second_soft_out;
        s_q.pin2_sel_reg[`SEL_MSB:0] == `SEL_SOFT && pin_direction[`PIN_SECOND];
    endsequence

    a_dir_gating: assert property (                                                   // RQ1
        !pin_direction[`PIN_SECOND] |=> !second_general_pin.level && !second_general_pin.oe)
        else $error("second pin driven while not an output");

    a_off_low: assert property (                                                      // RQ2
        s_q.pin2_sel_reg[`SEL_MSB:0] == `SEL_OFF && !invert[`PIN_SECOND]
        |=> !second_general_pin.level)
        else $error("off code did not hold pin low");

    a_dsp_route: assert property (                                                    // RQ3
        s_q.pin2_sel_reg[`SEL_MSB:0] == `SEL_DSP && pin_direction[`PIN_SECOND]
        |=> second_general_pin.level
            == ($past(dsp_pin_level[`PIN_SECOND]) ^ $past(invert[`PIN_SECOND])))
        else $error("dsp level not routed");

    a_soft_write: assert property (                                                   // RQ4 RQ15
        s_write_levels ##1 (s_second_soft_out and !invert[`PIN_SECOND])
        |=> second_general_pin.level == $past(reg_wdata[`PIN_SECOND_BIT], 2))
        else $error("soft level write not seen on second pin");

    a_auto_mute: assert property (                                                    // RQ5
        sel_code[`PIN_SECOND] == `SEL_AMUTE_BOTH
        |-> mux_out[`PIN_SECOND] == (flags.auto_mute_left && flags.auto_mute_right))
        else $error("auto-mute both flag wrong");

    a_serial_out: assert property (                                                   // RQ6
        sel_code[`PIN_FIRST] == `SEL_SERIAL_OUT
        |-> mux_out[`PIN_FIRST] == flags.serial_audio_out)
        else $error("serial audio out not routed");

    a_analog_mute: assert property (                                                  // RQ7
        sel_code[`PIN_SECOND] == `SEL_ANA_MUTE_R
        |-> mux_out[`PIN_SECOND] == flags.analog_mute_right_n)
        else $error("analog mute flag not routed");

    a_pll_div: assert property (                                                      // RQ9
        sel_code[`PIN_FIRST] == `SEL_PLL_DIV4 |-> mux_out[`PIN_FIRST] == pll_div4)
        else $error("divided pll clock not routed");

    a_clk_invalid: assert property (                                                  // RQ22
        sel_code[`PIN_SECOND] == `SEL_CLK_INVALID
        |-> mux_out[`PIN_SECOND]
            == (flags.clk_error || flags.clk_changing || flags.clk_missing))
        else $error("clock invalid flag wrong");

    a_reserved_zero: assert property (                                                // RQ14
        sel_code[`PIN_SECOND] inside {5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h14, 5'h1c,
                                      5'h1d, 5'h1e, 5'h1f}
        |-> !mux_out[`PIN_SECOND])
        else $error("unassigned code not zero");

    a_mute_invert: assert property (                                                  // RQ19 RQ23
        pin_direction[`PIN_MUTE] && sel_code[`PIN_MUTE] == `SEL_OFF
        |=> mute_pin.level == $past(invert[`PIN_MUTE]))
        else $error("mute pin inversion wrong");

    a_first_invert: assert property (                                                 // RQ20 RQ17
        pin_direction[`PIN_FIRST] ##0 sel_code[`PIN_FIRST] == `SEL_SOFT
        |=> first_general_pin.level
            == ($past(soft_level[`PIN_FIRST]) ^ $past(invert[`PIN_FIRST])))
        else $error("first pin soft level or inversion wrong");

    a_pll_lock: assert property ( // RQ8
        sel_code[`PIN_FIRST] == `SEL_PLL_LOCK
        |-> mux_out[`PIN_FIRST]
            == flags.pll_lock)
        else $error("pll lock wrong");

    a_offset_cal: assert property ( // RQ11
        sel_code[`PIN_MUTE] == `SEL_OFFSET_CAL
        |-> mux_out[`PIN_MUTE]
            == flags.offset_calibrating)
        else $error("offset cal flag wrong");

    a_clk_halt: assert property ( // RQ12
        sel_code[`PIN_FIRST] == `SEL_CLK_HALT
        |-> mux_out[`PIN_FIRST]
            == flags.clk_halt)
        else $error("clock halt flag wrong");

    a_pump_valid: assert property ( // RQ13
        sel_code[`PIN_SECOND] == `SEL_CP_VALID_N
        |-> mux_out[`PIN_SECOND]
            == flags.charge_pump_valid_n)
        else $error("pump valid flag wrong");

    a_mute_soft: assert property ( // RQ16
        sel_code[`PIN_MUTE] == `SEL_SOFT
        |-> mux_out[`PIN_MUTE]
            == s_q.levels_reg[`PIN_MUTE_BIT])
        else $error("mute soft level wrong");

    a_second_invert: assert property ( // RQ18
        pin_direction[`PIN_SECOND]
        |=> second_general_pin.level == ($past(mux_out[`PIN_SECOND])
            ^ $past(s_q.polarity_reg[`PIN_SECOND_BIT])))
        else $error("second invert wrong");

    a_read_die: assert property (
        reg_read && reg_addr == `ADDR_DIE_ID |=> reg_rvalid && reg_rdata == DIE_ID)
        else $error("die identifier read wrong");

endmodule
`default_nettype wire

// file: verif/board_pins.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// board side of the pins: pull-downs, undriven pins read low
// ----------------------------------------------------------------------------
module board_pins
    import gpio_out_pkg::*;
(
    input  wire pin_drive_type first_general_pin,
    input  wire pin_drive_type mute_pin,
    input  wire pin_drive_type second_general_pin,
    output wire logic [2:0]    wire_level
);
    assign wire_level[0] = first_general_pin.oe ? first_general_pin.level : 1'b0;
    assign wire_level[1] = mute_pin.oe ? mute_pin.level : 1'b0;
    assign wire_level[2] = second_general_pin.oe ? second_general_pin.level : 1'b0;
endmodule

`default_nettype wire

// file: verif/tb_gpio_output_select_control.sv
`timescale 1ns/1ns
`default_nettype none

module tb_gpio_output_select_control
    import gpio_out_pkg::*;
;
    localparam logic [7:0] DIE_ID = 8'h3c;   // arbitrary value

    typedef struct {
        string      name;
        logic [7:0] val;
    } note_type;

    logic             sys_clk = 1'b0;
    logic             reset = 1'b1;
    logic [7:0]       reg_addr = 8'h00;
    logic [7:0]       reg_wdata = 8'h00;
    logic             reg_write = 1'b0;
    logic             reg_read = 1'b0;
    logic [2:0]       pin_direction = 3'h0;
    source_code_type  mute_source_select = 5'h00;
    logic [2:0]       dsp_pin_level = 3'h0;
    source_flags_type flags = 16'h0000;
    logic             pll_clk = 1'b0;
    logic             osc_clk = 1'b0;
    logic [7:0]       reg_rdata;
    logic             reg_rvalid;
    pin_drive_type    first_general_pin;
    pin_drive_type    mute_pin;
    pin_drive_type    second_general_pin;
    wire logic [2:0]  wire_level;
    note_type         notes[$];
    note_type         nt;
    logic             probe = 1'b0;
    logic             div_run = 1'b0;
    int               dcnt = 0;
    integer           seed = 54251;
    int               n_errors = 0;
    int               total_checks = 0;
    logic [7:0]       lev;
    logic [7:0]       pol;
    source_flags_type fl;
    logic [2:0]       dsp;
    logic [2:0]       dir;
    int               n0;
    int               n2;
    logic             q0;
    logic             q2;
    logic             e;

    always #50 sys_clk = ~sys_clk;

    gpio_output_select_control #(.DIE_ID(DIE_ID)) i_gpio_output_select_control (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_write          (reg_write),
        .reg_read           (reg_read),
        .reg_rdata          (reg_rdata),
        .reg_rvalid         (reg_rvalid),
        .pin_direction      (pin_direction),
        .mute_source_select (mute_source_select),
        .dsp_pin_level      (dsp_pin_level),
        .flags              (flags),
        .pll_clk            (pll_clk),
        .osc_clk            (osc_clk),
        .first_general_pin  (first_general_pin),
        .mute_pin           (mute_pin),
        .second_general_pin (second_general_pin)
    );

    board_pins i_board_pins (
        .first_general_pin  (first_general_pin),
        .mute_pin           (mute_pin),
        .second_general_pin (second_general_pin),
        .wire_level         (wire_level)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string n);
        notes.push_back('{name: n, val: exp});
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
    endtask

    function automatic logic mux_exp(input logic [4:0] c, input logic d, input logic s,
                                     input source_flags_type f);
        case (c)
            5'h01: mux_exp = d;
            5'h02: mux_exp = s;
            5'h03: mux_exp = f.auto_mute_left & f.auto_mute_right;
            5'h04: mux_exp = f.auto_mute_left;
            5'h05: mux_exp = f.auto_mute_right;
            5'h06: mux_exp = f.clk_error | f.clk_changing | f.clk_missing;
            5'h07: mux_exp = f.serial_audio_out;
            5'h08: mux_exp = f.analog_mute_left_n;
            5'h09: mux_exp = f.analog_mute_right_n;
            5'h0a: mux_exp = f.pll_lock;
            5'h0b: mux_exp = f.charge_pump_clk;
            5'h12: mux_exp = f.imp_sense_left;
            5'h13: mux_exp = f.imp_sense_right;
            5'h15: mux_exp = f.offset_calibrating;
            5'h16: mux_exp = f.clk_error;
            5'h17: mux_exp = f.clk_changing;
            5'h18: mux_exp = f.clk_missing;
            5'h19: mux_exp = f.clk_halt;
            5'h1a: mux_exp = f.dsp_boot_done;
            5'h1b: mux_exp = f.charge_pump_valid_n;
            default: mux_exp = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // result monitor: oldest note against what appears
    // ------------------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (reg_rvalid === 1'b1) begin
            nt = notes.pop_front();
            check(nt.name, reg_rdata, nt.val);
        end
        if (probe === 1'b1) begin
            nt = notes.pop_front();
            check(nt.name, {6'h00, wire_level[0], first_general_pin.oe}, nt.val);
            nt = notes.pop_front();
            check(nt.name, {6'h00, wire_level[1], mute_pin.oe}, nt.val);
            nt = notes.pop_front();
            check(nt.name, {6'h00, wire_level[2], second_general_pin.oe}, nt.val);
        end
    end

    always @(posedge sys_clk) begin
        if (div_run) begin
            dcnt <= dcnt + 1;
            if (dcnt % 2 == 1) pll_clk <= ~pll_clk;
            if (dcnt % 3 == 2) osc_clk <= ~osc_clk;
        end
    end

    initial begin
        #(20000 * 100);
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        end_of_test();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h53, 8'h00, "sel0 reset");
        rd(8'h55, 8'h00, "sel2 reset");
        rd(8'h56, 8'h00, "levels reset");
        rd(8'h57, 8'h00, "polarity reset");
        rd(8'h58, DIE_ID, "die id");
        rd(8'h59, 8'h00, "unmapped");
        lev = 8'($random(seed));
        pol = 8'($random(seed));
        wr(8'h55, lev);
        wr(8'h57, pol);
        wr(8'h58, ~DIE_ID);
        rd(8'h55, lev, "sel2 rw");
        rd(8'h57, pol, "polarity rw");
        rd(8'h58, DIE_ID, "die id ro");
        for (int c = 0; c < 32; c++) begin
            if (c == 16 || c == 17) continue;
            lev = 8'($random(seed));
            pol = 8'($random(seed));
            fl = 16'($random(seed));
            dsp = 3'($random(seed));
            dir = 3'($random(seed));
            wr(8'h53, {3'h5, 5'(c)});
            wr(8'h55, {3'h2, 5'(c)});
            wr(8'h56, lev);
            wr(8'h57, pol);
            @(posedge sys_clk);
            flags <= fl;
            dsp_pin_level <= dsp;
            pin_direction <= dir;
            mute_source_select <= 5'(c);
            @(posedge sys_clk);
            for (int i = 0; i < 3; i++) begin
                e = (mux_exp(5'(c), dsp[i], lev[3 + i], fl) ^ pol[3 + i]) & dir[i];
                notes.push_back('{name: $sformatf("pin %0d code %h", i, c), val: {6'h00, e, dir[i]}});
            end
            probe <= 1'b1;
            @(posedge sys_clk);
            probe <= 1'b0;
        end
        wr(8'h53, 8'h10);
        wr(8'h55, 8'h11);
        wr(8'h57, 8'h00);
        @(posedge sys_clk);
        pin_direction <= 3'h5;
        div_run <= 1'b1;
        repeat (50) @(posedge sys_clk);
        @(negedge sys_clk);
        n0 = 0;
        n2 = 0;
        q0 = wire_level[0];
        q2 = wire_level[2];
        repeat (192) begin
            @(negedge sys_clk);
            if (wire_level[0] === 1'b1 && q0 === 1'b0) n0++;
            if (wire_level[2] === 1'b1 && q2 === 1'b0) n2++;
            q0 = wire_level[0];
            q2 = wire_level[2];
        end
        check("pll div4", 8'(n0), 8'h0c);
        check("osc div4", 8'(n2), 8'h08);
        end_of_test();
    end
endmodule

`default_nettype wire
